// file: dma_req_tracker.sv
// Synchronises the DMA request pins and remembers which lines are asserted.
// Assumes the pins are asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module dma_req_tracker #(
  parameter int LINES = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [LINES-1:0] dma_req_pin,
  track_if.src trk
);
  logic [LINES-1:0] meta_ff;
  logic [LINES-1:0] sync_ff;
  logic [LINES-1:0] record_ff;
  logic [LINES-1:0] nxt_record;

  // Record follows the line both ways, so a drop during retention is never missed
  always_comb begin
    nxt_record = sync_ff;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_ff <= '0;
      sync_ff <= '0;
      record_ff <= '0;
    end else begin
      meta_ff <= dma_req_pin;
      sync_ff <= meta_ff;
      record_ff <= nxt_record;
    end
  end

  assign trk.level = sync_ff;
  assign trk.record = record_ff;
  assign trk.fresh = |(sync_ff & ~record_ff);
endmodule : dma_req_tracker
`default_nettype wire

// file: dsp_dma_wakeup_control.sv
// Wake-up / standby control of the DSP subsystem and its DMA write completion modes.
// Assumes an Avalon-MM master on clk and a write target that accepts and answers on clk.
`timescale 1ns/100ps
`default_nettype none
`include "dwc_map.svh"

// Overview of operation
// - A fresh request edge against the remembered state wakes the DSP subsystem.
// - Writes are always posted while true completion is disabled.
// - True completion, together with the enable of the event type, turns writes into non-posted writes awaiting a response.
// - Intermediate events are non-posted when intermediate and true enables are set.
// - The final event is non-posted when final and true enables are set.
// - Standby is entered only once the outstanding write has completed.
// - One shared completion pulse serves both intermediate and final events.
module dsp_dma_wakeup_control #(
  parameter int LINES = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [LINES-1:0] dma_req_pin,
  input wire logic idle_req,
  output logic mst_write,
  output logic mst_read,
  output logic mst_posted,
  output logic mst_final,
  input wire logic mst_accept,
  input wire logic mst_resp,
  output logic completion_irq,
  output logic standby
);
  // Elaboration-time refusal: the status word has room for eight record bits only
  if (LINES < 1 || LINES > `DWC_MAX_LINES) begin : g_lines_check
    $error("LINES out of range");
  end

  // --------------------------------------------------------------------------
  // Request tracking
  // --------------------------------------------------------------------------
  track_if #(.LINES(LINES)) trk ();

  dma_req_tracker #(.LINES(LINES)) u_tracker (
    .clk(clk),
    .reset(reset),
    .dma_req_pin(dma_req_pin),
    .trk(trk)
  );

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [`DWC_CTRL_W-1:0] ctrl_ff, nxt_ctrl;
  logic [`DWC_CNT_W-1:0] remain_ff, nxt_remain;
  logic [31:0] rdata_ff, nxt_rdata;
  logic wait_ff, nxt_wait;
  logic done_ff, nxt_done;
  logic pend_ff, nxt_pend;
  logic wr_ff, nxt_wr, rd_ff, nxt_rd, posted_ff, nxt_posted, final_ff, nxt_final;
  logic irq_ff, nxt_irq;
  logic standby_ff, nxt_standby;
  dwc_pkg::eng_state_t state_ff, nxt_state;
  logic wr_done, evt_done, bus_done;
  logic [31:0] status_word;

  function automatic logic needs_resp(input logic last, input logic [`DWC_CTRL_W-1:0] c);
    needs_resp = c[`DWC_CTRL_TRUE] && (last ? c[`DWC_CTRL_FINAL] : c[`DWC_CTRL_INTER]);
  endfunction : needs_resp

  function automatic logic event_irq(input logic last, input logic [`DWC_CTRL_W-1:0] c);
    event_irq = last ? c[`DWC_CTRL_FINAL] : c[`DWC_CTRL_INTER];
  endfunction : event_irq

  always_comb begin
    status_word = '0;
    status_word[`DWC_ST_BUSY] = (state_ff != dwc_pkg::ST_IDLE);
    status_word[`DWC_ST_STBY] = standby_ff;
    status_word[`DWC_ST_DONE] = done_ff;
    status_word[`DWC_ST_PEND] = pend_ff;
    status_word[`DWC_ST_REC_LSB +: LINES] = trk.record;
    status_word[`DWC_ST_REM_LSB +: `DWC_CNT_W] = remain_ff;
  end

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_remain = remain_ff;
    nxt_rdata = rdata_ff;
    nxt_done = done_ff;
    nxt_pend = pend_ff;
    nxt_wr = wr_ff;
    nxt_rd = rd_ff;
    nxt_posted = posted_ff;
    nxt_final = final_ff;
    nxt_irq = 1'b0;
    nxt_standby = standby_ff;
    nxt_state = state_ff;
    wr_done = 1'b0;
    evt_done = 1'b0;
    // One wait cycle per access; the answer stands at the edge waitrequest is low
    bus_done = (avs_read || avs_write) && !wait_ff;
    nxt_wait = !((avs_read || avs_write) && wait_ff);
    if (avs_read && wait_ff) begin
      case (avs_address)
        `DWC_OFS_CTRL: nxt_rdata = {{(32-`DWC_CTRL_W){1'b0}}, ctrl_ff};
        `DWC_OFS_START: nxt_rdata = {{(32-`DWC_CNT_W){1'b0}}, remain_ff};
        `DWC_OFS_STATUS: nxt_rdata = status_word;
        default: nxt_rdata = '0;
      endcase
    end
    if (bus_done && avs_write) begin
      case (avs_address)
        `DWC_OFS_CTRL: nxt_ctrl = avs_writedata[`DWC_CTRL_W-1:0];
        `DWC_OFS_START: nxt_remain = avs_writedata[`DWC_CNT_W-1:0];
        `DWC_OFS_STATUS: begin
          if (avs_writedata[`DWC_ST_DONE]) begin
            nxt_done = 1'b0;
          end
        end
        default: ;
      endcase
    end
    case (state_ff)
      dwc_pkg::ST_IDLE: begin
        if (pend_ff && remain_ff != '0) begin
          nxt_pend = 1'b0;
          nxt_wr = 1'b1;
          nxt_final = (remain_ff == `DWC_CNT_W'(1));
          nxt_posted = !needs_resp(remain_ff == `DWC_CNT_W'(1), ctrl_ff);
          nxt_state = dwc_pkg::ST_WR;
        end
      end
      dwc_pkg::ST_WR: begin
        if (mst_accept) begin
          nxt_wr = 1'b0;
          if (posted_ff) begin
            wr_done = 1'b1;
          end else begin
            nxt_state = dwc_pkg::ST_WR_RESP;
          end
        end
      end
      dwc_pkg::ST_WR_RESP: begin
        wr_done = mst_resp;
      end
      dwc_pkg::ST_RD: begin
        if (mst_accept) begin
          nxt_rd = 1'b0;
          nxt_state = dwc_pkg::ST_RD_RESP;
        end
      end
      dwc_pkg::ST_RD_RESP: begin
        evt_done = mst_resp;
      end
      default: nxt_state = dwc_pkg::ST_IDLE;
    endcase
    if (wr_done) begin
      if (ctrl_ff[`DWC_CTRL_DUMMY]) begin
        nxt_rd = 1'b1;
        nxt_state = dwc_pkg::ST_RD;
      end else begin
        evt_done = 1'b1;
      end
    end
    if (evt_done) begin
      nxt_state = dwc_pkg::ST_IDLE;
      nxt_remain = remain_ff - `DWC_CNT_W'(1);
      nxt_irq = event_irq(final_ff, ctrl_ff);
      if (final_ff) begin
        nxt_done = 1'b1;
      end
    end
    if (trk.fresh) begin
      nxt_pend = 1'b1;
    end
    // Standby only from an idle engine: nothing outstanding on the write path
    if (standby_ff) begin
      if (trk.fresh) begin
        nxt_standby = 1'b0;
      end
    end else if (idle_req && state_ff == dwc_pkg::ST_IDLE && !pend_ff &&
                 trk.level == '0 && !trk.fresh) begin
      nxt_standby = 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_ff <= `DWC_CTRL_RST;
      remain_ff <= '0;
      rdata_ff <= '0;
      wait_ff <= 1'b1;
      done_ff <= 1'b0;
      pend_ff <= 1'b0;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      posted_ff <= 1'b1;
      final_ff <= 1'b0;
      irq_ff <= 1'b0;
      standby_ff <= 1'b0;
      state_ff <= dwc_pkg::ST_IDLE;
    end else begin
      ctrl_ff <= nxt_ctrl;
      remain_ff <= nxt_remain;
      rdata_ff <= nxt_rdata;
      wait_ff <= nxt_wait;
      done_ff <= nxt_done;
      pend_ff <= nxt_pend;
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      posted_ff <= nxt_posted;
      final_ff <= nxt_final;
      irq_ff <= nxt_irq;
      standby_ff <= nxt_standby;
      state_ff <= nxt_state;
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign mst_write = wr_ff;
  assign mst_read = rd_ff;
  assign mst_posted = posted_ff;
  assign mst_final = final_ff;
  assign completion_irq = irq_ff;
  assign standby = standby_ff;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_np_taken;
    wr_ff && mst_accept && !posted_ff;
  endsequence

  sequence s_write_finished;
    (wr_ff && mst_accept && posted_ff) or (state_ff == dwc_pkg::ST_WR_RESP && mst_resp);
  endsequence

  // Every return to idle closes one event, whichever completion path it took
  sequence s_event_closed;
    state_ff != dwc_pkg::ST_IDLE ##1 state_ff == dwc_pkg::ST_IDLE;
  endsequence

  AST_WAKE_ON_FRESH: assert property (
    standby_ff && trk.fresh |=> !standby_ff ##1 pend_ff || state_ff == dwc_pkg::ST_WR)
    else $error("fresh request did not wake the subsystem");
  AST_RECORD_CLEARS: assert property (
    trk.level == '0 |=> trk.record == '0)
    else $error("request record kept after line dropped");
  AST_POSTED_DEFAULT: assert property (
    wr_ff && !ctrl_ff[`DWC_CTRL_TRUE] && $stable(ctrl_ff) |-> posted_ff)
    else $error("write not posted with true completion off");
  AST_NP_WAITS: assert property (
    s_np_taken |=> state_ff == dwc_pkg::ST_WR_RESP && !wr_ff)
    else $error("non-posted write did not wait for a response");
  AST_INTER_NP: assert property (
    $rose(wr_ff) && !final_ff && $past(ctrl_ff[`DWC_CTRL_TRUE] && ctrl_ff[`DWC_CTRL_INTER])
    |-> !posted_ff)
    else $error("intermediate write posted despite enables");
  AST_FINAL_NP: assert property (
    $rose(wr_ff) && final_ff && $past(ctrl_ff[`DWC_CTRL_TRUE] && ctrl_ff[`DWC_CTRL_FINAL])
    |-> !posted_ff)
    else $error("final write posted despite enables");
  AST_STANDBY_QUIET: assert property (
    standby_ff |-> state_ff == dwc_pkg::ST_IDLE && !wr_ff && !rd_ff)
    else $error("standby while a transfer is outstanding");
  AST_SHARED_IRQ: assert property (
    s_event_closed |-> irq_ff == ($past(final_ff) ? $past(ctrl_ff[`DWC_CTRL_FINAL]) :
                                  $past(ctrl_ff[`DWC_CTRL_INTER])))
    else $error("completion pulse mismatch");
  AST_DUMMY_READ: assert property (
    s_write_finished ##0 ctrl_ff[`DWC_CTRL_DUMMY] |=> rd_ff && state_ff == dwc_pkg::ST_RD)
    else $error("dummy read not issued after write");
  AST_BUS_ANSWER: assert property (
    (avs_read || avs_write) && wait_ff |=> !wait_ff)
    else $error("bus answer not given in one cycle");
endmodule : dsp_dma_wakeup_control
`default_nettype wire

// file: dwc_map.svh
// Register offsets, field positions and reset values of the DSP wake-up control block.
// Assumes byte addressing on a 32-bit Avalon-MM slave port.
`ifndef DWC_MAP_SVH
`define DWC_MAP_SVH

// ----------------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------------
`define DWC_OFS_CTRL 4'h0
`define DWC_OFS_START 4'h4
`define DWC_OFS_STATUS 4'h8

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define DWC_CTRL_TRUE 0
`define DWC_CTRL_INTER 1
`define DWC_CTRL_FINAL 2
`define DWC_CTRL_DUMMY 3
`define DWC_CTRL_W 4
`define DWC_CTRL_RST 4'h0
`define DWC_CNT_W 8
`define DWC_ST_BUSY 0
`define DWC_ST_STBY 1
`define DWC_ST_DONE 2
`define DWC_ST_PEND 3
`define DWC_ST_REC_LSB 8
`define DWC_ST_REM_LSB 16
`define DWC_MAX_LINES 8

`endif

// file: dwc_pkg.sv
// Types shared by the DSP wake-up control block.
// Assumes nothing of its surroundings.
`default_nettype none
package dwc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WR,
    ST_WR_RESP,
    ST_RD,
    ST_RD_RESP
  } eng_state_t;
endpackage : dwc_pkg
`default_nettype wire

// file: dwc_target_model.sv
// Behavioural write target on the far side of the DSP wake-up control block.
// Assumes the request signals are registers on clk; delays are random.
`timescale 1ns/100ps
`default_nettype none
module dwc_target_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic mst_write,
  input wire logic mst_read,
  input wire logic mst_posted,
  input wire logic mst_final,
  output logic mst_accept,
  output logic mst_resp,
  output logic last_posted,
  output logic last_final,
  output int n_reads,
  output logic owe
);
  int wait_c;
  int resp_c;
  always @(posedge clk) begin
    mst_accept <= 1'b0;
    mst_resp <= 1'b0;
    if (reset) begin
      wait_c <= 0;
      owe <= 1'b0;
      n_reads <= 0;
      last_posted <= 1'b0;
      last_final <= 1'b0;
    end else if (owe) begin
      if (resp_c == 0) begin
        mst_resp <= 1'b1;
        owe <= 1'b0;
      end else begin
        resp_c <= resp_c - 1;
      end
    end else if ((mst_write || mst_read) && !mst_accept) begin
      if (wait_c == 0) begin
        mst_accept <= 1'b1;
        wait_c <= $urandom % 4;
        if (mst_read) begin
          n_reads <= n_reads + 1;
        end else begin
          last_posted <= mst_posted;
          last_final <= mst_final;
        end
        // Posted writes get no answer; a slow answer stretches the wait
        if (mst_read || !mst_posted) begin
          owe <= 1'b1;
          resp_c <= $urandom % 6;
        end
      end else begin
        wait_c <= wait_c - 1;
      end
    end
  end
endmodule : dwc_target_model
`default_nettype wire

// file: tb_top.sv
// Self-checking bench of the DSP wake-up control block.
// Assumes the target model answers every read and non-posted write it accepts.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk, reset, avs_read, avs_write, pin, idle_req;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic avs_waitrequest, mst_write, mst_read, mst_posted, mst_final;
  logic mst_accept, mst_resp, completion_irq, standby, l_post, l_fin, owe;
  int n_reads, n_irq, n_fail, n_compared, cnt, r0, q0;
  dsp_dma_wakeup_control dut (.clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dma_req_pin(pin),
    .idle_req(idle_req), .mst_write(mst_write), .mst_read(mst_read),
    .mst_posted(mst_posted), .mst_final(mst_final), .mst_accept(mst_accept),
    .mst_resp(mst_resp), .completion_irq(completion_irq), .standby(standby));
  dwc_target_model tgt (.clk(clk), .reset(reset), .mst_write(mst_write),
    .mst_read(mst_read), .mst_posted(mst_posted), .mst_final(mst_final),
    .mst_accept(mst_accept), .mst_resp(mst_resp), .last_posted(l_post),
    .last_final(l_fin), .n_reads(n_reads), .owe(owe));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (completion_irq === 1'b1) n_irq <= n_irq + 1;
    if (reset === 1'b0 && owe === 1'b1) chk("standby_wait", 0, standby);
  end
  // ---------------------------------------------------------------------------
  // Checks and bus cycles
  // ---------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  // Called just after a rising edge; holds the request until waitrequest is sampled low,
  // then lets one edge pass so a following call never reassigns a strobe in one step
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
    int i;
    avs_address <= a;
    avs_read <= !we;
    avs_write <= we;
    avs_writedata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      n_fail++;
      print_verdict();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus
  function automatic logic want_np(input logic [3:0] m, input logic f);
    return m[0] && (f ? m[2] : m[1]);
  endfunction : want_np
  task automatic one_event(input logic [3:0] m, input logic f);
    int i;
    r0 = n_reads;
    q0 = n_irq;
    pin <= 1'b1;
    for (i = 0; i < 50 && mst_write !== 1'b1; i++) @(posedge clk);
    if (i == 50) begin
      n_fail++;
      print_verdict();
    end
    chk("standby_wake", 0, standby);
    for (i = 0; i < 30; i++) begin
      bus(0, 4'h8, 0);
      if (rd[0] === 1'b0) break;
    end
    if (i == 30) begin
      n_fail++;
      print_verdict();
    end
    chk("posted", !want_np(m, f), l_post);
    chk("final", f, l_fin);
    chk("dummy_reads", m[3], n_reads - r0);
    chk("irq", f ? m[2] : m[1], n_irq - q0);
    repeat (6) @(posedge clk);
    bus(0, 4'h8, 0);
    chk("remaining_held", cnt - 1, rd[23:16]);
    chk("record_set", 1, rd[8]);
    pin <= 1'b0;
    repeat (6) @(posedge clk);
    bus(0, 4'h8, 0);
    chk("record_clear", 0, rd[8]);
    chk("standby", 1, rd[1]);
    cnt--;
  endtask : one_event
  initial begin
    {avs_read, avs_write, pin, idle_req} = 4'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    n_irq = 0;
    reset = 1'b1;
    void'($urandom(32'hED84D490));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    bus(0, 4'h0, 0);
    chk("ctrl_reset", 0, rd);
    bus(0, 4'h8, 0);
    chk("status_reset", 0, rd);
    bus(1, 4'hC, 32'hF);
    bus(0, 4'hC, 0);
    chk("unmapped", 0, rd);
    bus(0, 4'h0, 0);
    chk("ctrl_untouched", 0, rd);
    $display("test reset done");
    idle_req <= 1'b1;
    for (int m = 0; m < 16; m++) begin
      bus(1, 4'h0, m);
      bus(0, 4'h0, 0);
      chk("ctrl", m, rd);
      // Multi-event transfers stand for chained parameter sets; true plus
      // intermediate modes always get three so intermediate non-posted writes occur
      cnt = (m[1:0] == 2'b11) ? 3 : 1 + $urandom % 3;
      bus(1, 4'h4, cnt);
      while (cnt > 0) one_event(m[3:0], cnt == 1);
      bus(0, 4'h8, 0);
      chk("done", 1, rd[2]);
      bus(1, 4'h8, 32'h4);
      bus(0, 4'h8, 0);
      chk("done_clear", 0, rd[2]);
      $display("test mode %0d done", m);
    end
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire

// file: track_if.sv
// Request tracking signals from the request tracker to the control core.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface track_if #(parameter int LINES = 1);
  logic [LINES-1:0] level;
  logic [LINES-1:0] record;
  logic fresh;
  modport src (output level, output record, output fresh);
  modport dst (input level, input record, input fresh);
endinterface : track_if
`default_nettype wire
